// File: hw/iskp_defines.svh
// constants for the increment and bit skip execution block
`ifndef ISKP_DEFINES_SVH
`define ISKP_DEFINES_SVH

`define ISKP_DATA_W 8
`define ISKP_ADDR_W 8
`define ISKP_BIT_W 3
`define ISKP_FLAG_W 6
`define ISKP_MEM_DEPTH 256
`define ISKP_ACC_RST 8'h00
`define ISKP_FLAGS_RST 6'h00
`define ISKP_ONE 8'h01
`define ISKP_ZERO 8'h00

`endif

// File: hw/iskp_pkg.sv
// types shared by the increment and bit skip execution block
`include "iskp_defines.svh"

package iskp_pkg;

    // the three skip instructions this unit executes
    typedef enum logic [1:0] {
        op_incr_mem_skip_zero,
        op_incr_to_acc_skip_zero,
        op_bit_set_skip
    } iskp_op_e;

    // sequencing: execute, then two cycles for a taken skip
    typedef enum logic [1:0] {
        st_idle,
        st_exec,
        st_dummy,
        st_skip
    } iskp_state_e;

    // one issued instruction
    typedef struct packed {
        iskp_op_e op;
        logic [`ISKP_ADDR_W-1:0] addr;
        logic [`ISKP_BIT_W-1:0] bit_sel;
    } iskp_req_s;

    // status flags, held but never altered by this unit
    typedef struct packed {
        logic cz;
        logic sc;
        logic ov;
        logic ac;
        logic z;
        logic c;
    } iskp_flags_s;

endpackage : iskp_pkg

// File: hw/iskp_exec.sv
// execution unit for the increment-skip and bit-test-skip instructions
`include "iskp_defines.svh"

module iskp_exec (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire iskp_pkg::iskp_req_s req_i,
    input wire logic mem_wr_i,
    input wire logic [`ISKP_ADDR_W-1:0] mem_wr_addr_i,
    input wire logic [`ISKP_DATA_W-1:0] mem_wr_data_i,
    input wire logic [`ISKP_ADDR_W-1:0] mem_rd_addr_i,
    input wire logic acc_ld_i,
    input wire logic [`ISKP_DATA_W-1:0] acc_ld_data_i,
    input wire logic flags_ld_i,
    input wire iskp_pkg::iskp_flags_s flags_ld_data_i,
    output logic [`ISKP_DATA_W-1:0] mem_rd_data_o,
    output logic [`ISKP_DATA_W-1:0] accumulator_o,
    output iskp_pkg::iskp_flags_s flags_o,
    output logic busy_o,
    output logic dummy_o,
    output logic done_o,
    output logic skip_o
);
    import iskp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // skip decision, used by the issue logic (the checks work it out on their own)
    function automatic logic skip_taken(
        input iskp_op_e op,
        input logic [`ISKP_DATA_W-1:0] old_val,
        input logic [`ISKP_BIT_W-1:0] bit_sel
    );
        logic [`ISKP_DATA_W-1:0] inc;
        inc = 8'(old_val + `ISKP_ONE);
        case (op)
            op_incr_mem_skip_zero: skip_taken = (inc == `ISKP_ZERO);
            op_incr_to_acc_skip_zero: skip_taken = (inc == `ISKP_ZERO);
            op_bit_set_skip: skip_taken = old_val[bit_sel];
            default: skip_taken = 1'b0;
        endcase
    endfunction : skip_taken

    ////////////////////////////////////////////////////////////////////////
    logic [`ISKP_DATA_W-1:0] mem_q [`ISKP_MEM_DEPTH];
    iskp_state_e state_q;
    iskp_req_s req_q;
    logic [`ISKP_DATA_W-1:0] old_q;
    logic take_q;
    logic accept;
    logic [`ISKP_DATA_W-1:0] rd_val;
    logic [`ISKP_DATA_W-1:0] inc_val;
    logic take_d;

    // issue only from idle; requests while busy are dropped
    assign accept = go_i && (state_q == st_idle);
    assign rd_val = mem_q[req_i.addr];
    assign inc_val = 8'(rd_val + `ISKP_ONE);
    assign take_d = skip_taken(req_i.op, rd_val, req_i.bit_sel);

    // data memory: increment write-back, else side load while idle
    always_ff @(posedge mclk_i) begin
        if (accept && req_i.op == op_incr_mem_skip_zero) begin
            mem_q[req_i.addr] <= inc_val;
        end else if (mem_wr_i && state_q == st_idle && !go_i) begin
            mem_q[mem_wr_addr_i] <= mem_wr_data_i;
        end
    end

    // registered read port for the rest of the core
    always_ff @(posedge mclk_i) begin
        mem_rd_data_o <= mem_q[mem_rd_addr_i];
    end

    // accumulator: the accumulator form writes it here, else side load while idle
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            accumulator_o <= `ISKP_ACC_RST;
        end else if (accept && req_i.op == op_incr_to_acc_skip_zero) begin
            accumulator_o <= inc_val;
        end else if (acc_ld_i && state_q == st_idle && !go_i) begin
            accumulator_o <= acc_ld_data_i;
        end
    end

    // flags: loads only while idle, so a skip never disturbs them
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            flags_o <= `ISKP_FLAGS_RST;
        end else if (flags_ld_i && state_q == st_idle && !go_i) begin
            flags_o <= flags_ld_data_i;
        end
    end

    // capture of the issued instruction and its decision
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            req_q <= '0;
            old_q <= `ISKP_ZERO;
            take_q <= 1'b0;
        end else if (accept) begin
            req_q <= req_i;
            old_q <= rd_val;
            take_q <= take_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: one cycle plain, three when the skip is taken
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_q <= st_idle;
            busy_o <= 1'b0;
            dummy_o <= 1'b0;
            done_o <= 1'b0;
            skip_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (state_q)
                st_idle: begin
                    skip_o <= 1'b0;
                    if (accept) begin
                        state_q <= st_exec;
                        busy_o <= 1'b1;
                    end
                end
                st_exec: begin
                    if (take_q) begin
                        state_q <= st_dummy;
                        dummy_o <= 1'b1;
                    end else begin
                        state_q <= st_idle;
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                    end
                end
                // dummy slot while the skipped word is fetched
                st_dummy: begin
                    state_q <= st_skip;
                end
                st_skip: begin
                    state_q <= st_idle;
                    busy_o <= 1'b0;
                    dummy_o <= 1'b0;
                    done_o <= 1'b1;
                    skip_o <= 1'b1;
                end
                default: begin
                    state_q <= st_idle;
                    busy_o <= 1'b0;
                    dummy_o <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    chk_mem_incr_wb: assert property (
        (state_q == st_exec && req_q.op == op_incr_mem_skip_zero)
        |-> (mem_q[req_q.addr] == 8'(old_q + `ISKP_ONE))
            && (take_q == (mem_q[req_q.addr] == `ISKP_ZERO)))
        else $error("memory increment result or skip wrong");

    chk_skip_three_cyc: assert property (
        (state_q == st_exec && take_q)
        |-> busy_o [*3] ##1 (done_o && skip_o && !busy_o))
        else $error("taken skip did not last three cycles");

    chk_no_skip_one: assert property (
        (state_q == st_exec && !take_q)
        |=> (done_o && !skip_o && !busy_o && !dummy_o))
        else $error("untaken skip did not finish after one cycle");

    chk_acc_form: assert property (
        (state_q == st_exec && req_q.op == op_incr_to_acc_skip_zero)
        |-> (accumulator_o == 8'(old_q + `ISKP_ONE))
            && (mem_q[req_q.addr] == old_q)
            && (take_q == (accumulator_o == `ISKP_ZERO)))
        else $error("accumulator form result, memory or skip wrong");

    chk_bit_test: assert property (
        (state_q == st_exec && req_q.op == op_bit_set_skip)
        |-> (take_q == old_q[req_q.bit_sel])
            && (mem_q[req_q.addr] == old_q))
        else $error("bit test skip decision wrong");

    chk_flags_hold: assert property (
        (busy_o || accept) |=> $stable(flags_o))
        else $error("status flags changed by a skip instruction");

    chk_wrap_skip: assert property (
        (accept && req_i.op != op_bit_set_skip && rd_val == 8'hFF)
        |=> take_q && old_q == 8'hFF)
        else $error("all ones increment did not wrap and skip");

    // the memory form and the bit test leave the accumulator alone,
    // and nothing reloads it while an instruction is in flight
    chk_acc_kept: assert property (
        ((accept && req_i.op != op_incr_to_acc_skip_zero) || busy_o)
        |=> $stable(accumulator_o))
        else $error("accumulator changed by a memory skip instruction");

    // two dummy slots, then the done cycle without one
    chk_dummy_slots: assert property (
        (state_q == st_exec && take_q)
        |=> (dummy_o && !done_o) ##1 (dummy_o && !done_o) ##1 !dummy_o)
        else $error("dummy slots of a taken skip wrong");

    // skip only means something beside the done pulse
    chk_skip_with_done: assert property (
        skip_o |-> done_o)
        else $error("skip flag seen outside a done cycle");

endmodule : iskp_exec

// File: dv/iskp_exec_tb_top.sv
// self-checking bench for the increment and bit skip execution unit
module iskp_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import iskp_pkg::*;

    logic mclk_i, rst_i, go_i, mem_wr_i, acc_ld_i, flags_ld_i;
    iskp_req_s req_i;
    logic [7:0] mem_wr_addr_i, mem_wr_data_i, mem_rd_addr_i, acc_ld_data_i;
    iskp_flags_s flags_ld_data_i, flags_o;
    logic [7:0] mem_rd_data_o, accumulator_o;
    logic busy_o, dummy_o, done_o, skip_o;
    int fails, num_checks;
    // mixed set and clear flags so a stray write in either sense shows
    localparam iskp_flags_s FLG = 6'h2d;

    iskp_exec u_dut (
        .mclk_i, .rst_i, .go_i, .req_i, .mem_wr_i, .mem_wr_addr_i,
        .mem_wr_data_i, .mem_rd_addr_i, .acc_ld_i, .acc_ld_data_i,
        .flags_ld_i, .flags_ld_data_i, .mem_rd_data_o, .accumulator_o,
        .flags_o, .busy_o, .dummy_o, .done_o, .skip_o
    );

    // 20 MHz system clock
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // verdict, reached from the main sequence or a timed-out wait
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [7:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got,
                     exp);
        end
    endtask : check

    // side write, taken only while idle
    task automatic poke(input logic [7:0] a, d);
        @(posedge mclk_i);
        mem_wr_i <= 1'b1;
        mem_wr_addr_i <= a;
        mem_wr_data_i <= d;
        @(posedge mclk_i);
        mem_wr_i <= 1'b0;
    endtask : poke

    // registered read port: data settles one edge after the address
    task automatic peek(input logic [7:0] a, exp);
        @(posedge mclk_i);
        mem_rd_addr_i <= a;
        @(posedge mclk_i);
        @(negedge mclk_i);
        check(mem_rd_data_o, exp, "memory byte");
    endtask : peek

    // one instruction; counts cycles to done and dummy cycles on the way
    task automatic issue(input iskp_op_e op, input logic [7:0] a,
                         input logic [2:0] b, input logic sk);
        int n, dm, bz;
        @(posedge mclk_i);
        go_i <= 1'b1;
        req_i <= {op, a, b};
        // a flag load on the issue edge must be dropped
        flags_ld_i <= 1'b1;
        flags_ld_data_i <= ~FLG;
        @(posedge mclk_i);
        go_i <= 1'b0;
        flags_ld_i <= 1'b0;
        n = 0;
        dm = 0;
        bz = 0;
        // bounded wait, done is due on the 2nd or 4th cycle
        do begin
            @(negedge mclk_i);
            n++;
            if (dummy_o === 1'b1) dm++;
            if (busy_o === 1'b1) bz++;
        end while (done_o !== 1'b1 && n < 8);
        if (done_o !== 1'b1) begin
            fails++;
            $display("mismatch at %0t: no done pulse", $time);
            complete_run();
        end else begin
            check(8'(n), sk ? 8'h04 : 8'h02, "cycle count");
            check(8'(dm), sk ? 8'h02 : 8'h00, "dummy cycles");
            check(8'(bz), sk ? 8'h03 : 8'h01, "busy cycles");
            check({7'h00, skip_o}, {7'h00, sk}, "skip");
            check({2'b00, flags_o}, {2'b00, FLG}, "flags");
        end
    endtask : issue

    ////////////////////////////////////////////////////////////////////////
    task automatic t_mem_incr();
        poke(8'h10, 8'h41);
        issue(op_incr_mem_skip_zero, 8'h10, 3'h0, 1'b0);
        peek(8'h10, 8'h42);
        check(accumulator_o, 8'h55, "accumulator kept");
        poke(8'h11, 8'hff);
        issue(op_incr_mem_skip_zero, 8'h11, 3'h0, 1'b1);
        peek(8'h11, 8'h00);
        $display("memory increment test done");
    endtask : t_mem_incr

    task automatic t_acc_incr();
        poke(8'h20, 8'hff);
        issue(op_incr_to_acc_skip_zero, 8'h20, 3'h0, 1'b1);
        check(accumulator_o, 8'h00, "accumulator wrap");
        peek(8'h20, 8'hff);
        poke(8'h21, 8'h7f);
        issue(op_incr_to_acc_skip_zero, 8'h21, 3'h0, 1'b0);
        check(accumulator_o, 8'h80, "accumulator");
        peek(8'h21, 8'h7f);
        $display("accumulator increment test done");
    endtask : t_acc_incr

    // every bit position, half of them set
    task automatic t_bit_test();
        logic [7:0] pat;
        pat = 8'h5a;
        poke(8'h30, pat);
        for (int b = 0; b < 8; b++) begin
            issue(op_bit_set_skip, 8'h30, 3'(b), pat[b]);
        end
        peek(8'h30, pat);
        check(accumulator_o, 8'h80, "accumulator kept");
        $display("bit test done");
    endtask : t_bit_test

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {go_i, mem_wr_i, acc_ld_i, flags_ld_i} = 4'h0;
        req_i = '0;
        {mem_wr_addr_i, mem_wr_data_i, mem_rd_addr_i, acc_ld_data_i} = '0;
        flags_ld_data_i = '0;
        rst_i = 1'b1;
        fails = 0;
        num_checks = 0;
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(negedge mclk_i);
        check(accumulator_o, 8'h00, "accumulator reset");
        check({2'b00, flags_o}, 8'h00, "flags reset");
        @(posedge mclk_i);
        flags_ld_i <= 1'b1;
        flags_ld_data_i <= FLG;
        acc_ld_i <= 1'b1;
        acc_ld_data_i <= 8'h55;
        @(posedge mclk_i);
        flags_ld_i <= 1'b0;
        acc_ld_i <= 1'b0;
        @(negedge mclk_i);
        check(accumulator_o, 8'h55, "accumulator load");
        check({2'b00, flags_o}, {2'b00, FLG}, "flags load");
        t_mem_incr();
        t_acc_incr();
        t_bit_test();
        complete_run();
    end
endmodule : iskp_exec_tb_top
